/* logic/rst_seq_pkg.sv */
// How it works
// - Five reset sources feed one sequencer
// - Power-up holds internal reset about 22 ms
// - Ready reads 0 until power-up completes
// - Low reset pin resets; ready follows completion
// - Reset pin is weakly pulled high
// - Wake write sets ready within 2 ms
// - Soft reset bit self-clears after 2 us
// - Soft reset spares marked bits and bus
// - Power control bit 10 resets PHY 100 us
// - PHY control bit 15 self-clears when done
// - Main resets start automatic EEPROM probe
package rst_seq_pkg;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POR_TIME_NS   = 22_000_000;
    localparam int unsigned SOFT_TIME_NS  = 2_000;
    localparam int unsigned PHY_TIME_NS   = 100_000;
    localparam int unsigned WAKE_TIME_NS  = 2_000_000;
    localparam int unsigned POR_CYCLES    = POR_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned SOFT_CYCLES   = SOFT_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned PHY_CYCLES    = PHY_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CYCLES   = WAKE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned PIN_CYCLES    = 1;
    localparam int unsigned TMR_W         = 22;

    // Register offsets
    localparam logic [7:0] OFS_HW_CONFIG_REG  = 8'h00;
    localparam logic [7:0] OFS_PM_CTRL = 8'h04;
    localparam logic [7:0] OFS_EEPROM_COMMAND_REG = 8'h08;
    localparam logic [7:0] OFS_PHY_BC  = 8'h0c;
    localparam logic [7:0] OFS_WAKE    = 8'h10;
    localparam logic [7:0] OFS_STA_HI  = 8'h14;
    localparam logic [7:0] OFS_STA_LO  = 8'h18;

    // Field positions
    localparam int unsigned HW_SOFT_RESET_BIT_BIT    = 0;
    localparam int unsigned HW_CTRL_LSB    = 16;
    localparam int unsigned HW_KEEP_LSB    = 20;
    localparam int unsigned PM_READY_BIT   = 0;
    localparam int unsigned PM_PHY_RST_BIT = 10;
    localparam int unsigned PM_MODE_LSB    = 12;
    localparam int unsigned E2P_BUSY_BIT   = 31;
    localparam int unsigned PHY_BC_RST_BIT = 15;

    // Reset values
    localparam logic [3:0]  HW_CTRL_RST = 4'h0;
    localparam logic [3:0]  HW_KEEP_RST = 4'h0;
    localparam logic [1:0]  PM_MODE_RST = 2'h0;
    localparam logic [30:0] E2P_RST     = 31'h0000_0000;
    localparam logic [14:0] PHY_BC_RST  = 15'h0000;
    localparam logic [15:0] STA_HI_RST  = 16'h0000;
    localparam logic [31:0] STA_LO_RST  = 32'h0000_0000;

    typedef enum logic [5:0] {
        ST_HOLD  = 6'b00_0001,
        ST_PIN   = 6'b00_0010,
        ST_SOFT  = 6'b00_0100,
        ST_RUN   = 6'b00_1000,
        ST_SLEEP = 6'b01_0000,
        ST_WAKE  = 6'b10_0000
    } seq_state_t;
endpackage : rst_seq_pkg

/* logic/timer_if.sv */
`timescale 1ns/100ps
interface timer_if;
    import rst_seq_pkg::*;
    logic             start;
    logic [TMR_W-1:0] load;
    logic             busy;
    logic             done;
    modport ctl (output start, output load, input busy, input done);
    modport tmr (input start, input load, output busy, output done);
endinterface : timer_if

/* logic/reset_timer.sv */
`timescale 1ns/100ps
module reset_timer
    import rst_seq_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    timer_if.tmr      t
);
    logic [TMR_W-1:0] cnt_q;

    // Busy for exactly load cycles, then one done pulse; start restarts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            t.busy <= 1'b0;
            t.done <= 1'b0;
        end else begin
            t.done <= 1'b0;
            if (t.start) begin
                cnt_q  <= t.load;
                t.busy <= 1'b1;
            end else if (t.busy) begin
                if (cnt_q <= TMR_W'(1)) begin
                    t.busy <= 1'b0;
                    t.done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - TMR_W'(1);
                end
            end
        end
    end
endmodule : reset_timer

/* logic/reset_source_sequencer.sv */
`timescale 1ns/100ps
module reset_source_sequencer
    import rst_seq_pkg::*;
#(
    parameter int unsigned POR_COUNT  = POR_CYCLES,
    parameter int unsigned PHY_COUNT  = PHY_CYCLES,
    parameter int unsigned WAKE_COUNT = WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Reset pin
    input  wire logic        hw_reset_pin_n_i,
    output logic             hw_reset_pull_en_o,
    // EEPROM probe
    output logic             eeprom_probe_o,
    input  wire logic        eeprom_probe_done_i,
    // Reset and status outputs
    output logic             chip_reset_o,
    output logic             phy_reset_o,
    output logic             device_ready_o,
    output logic             sleep_o
);
    timer_if main_t ();
    timer_if phy_t ();

    seq_state_t  state_q;
    seq_state_t  state_d;
    logic        por_kick_q;
    logic        read_seen_q;
    logic        eeprom_busy_flag_q;
    logic        pm_phy_rst_q;
    logic        bc_phy_rst_q;
    logic [3:0]  hw_ctrl_q;
    logic [3:0]  hw_keep_q;
    logic [1:0]  pm_mode_q;
    logic [30:0] eeprom_command_reg_q;
    logic [14:0] phy_bc_q;
    logic [15:0] sta_hi_q;
    logic [31:0] sta_lo_q;
    logic        ack_q;
    logic        wr_take;
    logic        rd_take;
    logic        wr_cfg;
    logic [31:0] merged;
    logic        soft_go;
    logic        sleep_go;
    logic        wake_go;
    logic        phy_go_pm;
    logic        phy_go_bc;
    logic        probe_go;
    logic        full_clr;
    logic [31:0] rd_data;

    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : apply_sel

    function automatic logic is_reset_state(input seq_state_t s);
        return (s == ST_HOLD) || (s == ST_PIN) || (s == ST_SOFT);
    endfunction : is_reset_state

    reset_timer u_main_tmr (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .t     (main_t)
    );

    reset_timer u_phy_tmr (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .t     (phy_t)
    );

    // Bus handshake, untouched by soft reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    // Write and read take effect at the edge where ack is seen
    always_comb begin
        rd_take  = wb_cyc_i && wb_stb_i && !wb_we_i && ack_q;
        wr_take  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && read_seen_q;
        wr_cfg   = wr_take && (state_q == ST_RUN);
        merged   = apply_sel(rd_data, wb_dat_i, wb_sel_i);
        soft_go  = wr_cfg && (wb_adr_i == OFS_HW_CONFIG_REG) && merged[HW_SOFT_RESET_BIT_BIT];
        phy_go_pm = wr_cfg && (wb_adr_i == OFS_PM_CTRL) && merged[PM_PHY_RST_BIT];
        phy_go_bc = wr_cfg && (wb_adr_i == OFS_PHY_BC) && merged[PHY_BC_RST_BIT];
        sleep_go = wr_cfg && (wb_adr_i == OFS_PM_CTRL) &&
                   (merged[PM_MODE_LSB +: 2] != 2'b00);
        wake_go  = wr_take && (state_q == ST_SLEEP) && (wb_adr_i == OFS_WAKE);
        probe_go = main_t.done && hw_reset_pin_n_i && ((state_q == ST_HOLD) || (state_q == ST_SOFT));
        full_clr = rst_i || (state_q == ST_PIN);
    end

    // Sequencer
    always_comb begin
        state_d = state_q;
        if (!hw_reset_pin_n_i) begin
            state_d = ST_PIN;
        end else begin
            case (state_q)
                ST_HOLD: begin
                    if (main_t.done) begin
                        state_d = ST_RUN;
                    end
                end
                ST_PIN: begin
                    state_d = ST_HOLD;
                end
                ST_SOFT: begin
                    if (main_t.done) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (soft_go) begin
                        state_d = ST_SOFT;
                    end else if (sleep_go) begin
                        state_d = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_go) begin
                        state_d = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (main_t.done) begin
                        state_d = ST_RUN;
                    end
                end
                default: begin
                    state_d = ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= ST_HOLD;
            por_kick_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            por_kick_q <= 1'b0;
        end
    end

    // Main timer: power-up, pin recovery, soft reset and wake
    always_comb begin
        main_t.start = 1'b0;
        main_t.load  = TMR_W'(POR_COUNT);
        if (por_kick_q) begin
            main_t.start = 1'b1;
        end else if ((state_q == ST_PIN) && hw_reset_pin_n_i) begin
            main_t.start = 1'b1;
            main_t.load  = TMR_W'(PIN_CYCLES);
        end else if (soft_go) begin
            main_t.start = 1'b1;
            main_t.load  = TMR_W'(SOFT_CYCLES);
        end else if (wake_go) begin
            main_t.start = 1'b1;
            main_t.load  = TMR_W'(WAKE_COUNT);
        end
    end

    // PHY-only timer
    always_comb begin
        phy_t.start = phy_go_pm || phy_go_bc;
        phy_t.load  = TMR_W'(PHY_COUNT);
    end

    // Self-clearing PHY reset bits; a new request wins over completion
    always_ff @(posedge clk_i) begin
        if (full_clr) begin
            pm_phy_rst_q <= 1'b0;
            bc_phy_rst_q <= 1'b0;
        end else begin
            if (phy_go_pm) begin
                pm_phy_rst_q <= 1'b1;
            end else if (phy_t.done) begin
                pm_phy_rst_q <= 1'b0;
            end
            if (phy_go_bc) begin
                bc_phy_rst_q <= 1'b1;
            end else if (phy_t.done) begin
                bc_phy_rst_q <= 1'b0;
            end
        end
    end

    // First read after a power-up, pin or soft reset or a sleep request unlocks writes
    always_ff @(posedge clk_i) begin
        if (full_clr || soft_go || sleep_go || (state_q == ST_HOLD)) begin
            read_seen_q <= 1'b0;
        end else if (rd_take) begin
            read_seen_q <= 1'b1;
        end
    end

    // EEPROM probe after power-up, pin or soft reset
    always_ff @(posedge clk_i) begin
        if (full_clr) begin
            eeprom_busy_flag_q <= 1'b0;
            eeprom_probe_o     <= 1'b0;
        end else begin
            eeprom_probe_o <= probe_go;
            if (probe_go) begin
                eeprom_busy_flag_q <= 1'b1;
            end else if (eeprom_probe_done_i) begin
                eeprom_busy_flag_q <= 1'b0;
            end
        end
    end

    // Configuration registers; marked bits and station address keep soft reset
    always_ff @(posedge clk_i) begin
        if (full_clr) begin
            hw_keep_q <= HW_KEEP_RST;
            sta_hi_q  <= STA_HI_RST;
            sta_lo_q  <= STA_LO_RST;
        end else if (wr_cfg && !soft_go) begin
            if (wb_adr_i == OFS_HW_CONFIG_REG) begin
                hw_keep_q <= merged[HW_KEEP_LSB +: 4];
            end
            if (wb_adr_i == OFS_STA_HI) begin
                sta_hi_q <= merged[15:0];
            end
            if (wb_adr_i == OFS_STA_LO) begin
                sta_lo_q <= merged;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (full_clr || soft_go) begin
            hw_ctrl_q <= HW_CTRL_RST;
            eeprom_command_reg_q <= E2P_RST;
        end else if (wr_cfg) begin
            if (wb_adr_i == OFS_HW_CONFIG_REG) begin
                hw_ctrl_q <= merged[HW_CTRL_LSB +: 4];
            end
            if (wb_adr_i == OFS_EEPROM_COMMAND_REG) begin
                eeprom_command_reg_q <= merged[30:0];
            end
        end
    end

    // PHY control storage is left alone by soft reset
    always_ff @(posedge clk_i) begin
        if (full_clr) begin
            phy_bc_q <= PHY_BC_RST;
        end else if (wr_cfg && (wb_adr_i == OFS_PHY_BC)) begin
            phy_bc_q <= merged[14:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (full_clr || soft_go || (wake_go)) begin
            pm_mode_q <= PM_MODE_RST;
        end else if (sleep_go) begin
            pm_mode_q <= merged[PM_MODE_LSB +: 2];
        end
    end

    // Read mux
    always_comb begin
        rd_data = '0;
        case (wb_adr_i)
            OFS_HW_CONFIG_REG: begin
                rd_data[HW_SOFT_RESET_BIT_BIT]         = (state_q == ST_SOFT);
                rd_data[HW_CTRL_LSB +: 4]    = hw_ctrl_q;
                rd_data[HW_KEEP_LSB +: 4]    = hw_keep_q;
            end
            OFS_PM_CTRL: begin
                rd_data[PM_READY_BIT]        = (state_q == ST_RUN);
                rd_data[PM_PHY_RST_BIT]      = pm_phy_rst_q;
                rd_data[PM_MODE_LSB +: 2]    = pm_mode_q;
            end
            OFS_EEPROM_COMMAND_REG: begin
                rd_data[E2P_BUSY_BIT]        = eeprom_busy_flag_q;
                rd_data[30:0]                = eeprom_command_reg_q;
            end
            OFS_PHY_BC: begin
                rd_data[PHY_BC_RST_BIT]      = bc_phy_rst_q;
                rd_data[14:0]                = phy_bc_q;
            end
            OFS_STA_HI: begin
                rd_data[15:0]                = sta_hi_q;
            end
            OFS_STA_LO: begin
                rd_data                      = sta_lo_q;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chip_reset_o       <= 1'b1;
            phy_reset_o        <= 1'b1;
            device_ready_o     <= 1'b0;
            sleep_o            <= 1'b0;
            hw_reset_pull_en_o <= 1'b1;
        end else begin
            chip_reset_o       <= is_reset_state(state_d);
            phy_reset_o        <= (state_d == ST_HOLD) || (state_d == ST_PIN) ||
                                  phy_t.start || (phy_t.busy && !phy_t.done);
            device_ready_o     <= (state_d == ST_RUN);
            sleep_o            <= (state_d == ST_SLEEP);
            hw_reset_pull_en_o <= 1'b1;
        end
    end
endmodule : reset_source_sequencer

/* verif/reset_source_sequencer_assertions.sv */
`timescale 1ns/100ps
module reset_source_sequencer_assertions
    import rst_seq_pkg::*;
#(
    parameter int unsigned POR_COUNT = POR_CYCLES,
    parameter int unsigned PHY_COUNT = PHY_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin and probe
    input wire logic hw_reset_pin_n_i,
    input wire logic hw_reset_pull_en_o,
    input wire logic eeprom_probe_o,
    // Status
    input wire logic chip_reset_o,
    input wire logic phy_reset_o,
    input wire logic device_ready_o
);
    int unsigned por_cnt_q;
    logic        por_on_q;
    int unsigned phy_cnt_q;
    logic        phy_sw_q;

    // Cycles from reset release to ready
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_cnt_q <= 0;
            por_on_q  <= 1'b1;
        end else if (por_on_q) begin
            por_cnt_q <= por_cnt_q + 1;
            por_on_q  <= !device_ready_o;
        end
    end

    // Length of a PHY reset started by software
    always_ff @(posedge clk_i) begin
        phy_cnt_q <= phy_reset_o ? phy_cnt_q + 1 : 0;
        phy_sw_q  <= !rst_i && !chip_reset_o && phy_reset_o && ($rose(phy_reset_o) || phy_sw_q);
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    pull_up_a: assert property (hw_reset_pull_en_o)
        else $error("pull-up enable low");
    ready_gate_a: assert property (chip_reset_o |-> !device_ready_o)
        else $error("ready while in reset");
    pin_reset_a: assert property (!hw_reset_pin_n_i |=> chip_reset_o && phy_reset_o && !device_ready_o)
        else $error("pin low did not reset");
    por_time_a: assert property ($rose(device_ready_o) && por_on_q |->
        por_cnt_q >= POR_COUNT && por_cnt_q <= POR_COUNT + 4)
        else $error("power-up hold length wrong");
    probe_start_a: assert property ($rose(device_ready_o) && $past(chip_reset_o) |-> eeprom_probe_o)
        else $error("no probe after main reset");
    probe_pulse_a: assert property (eeprom_probe_o |-> $rose(device_ready_o) ##1 !eeprom_probe_o)
        else $error("stray or long probe");
    phy_only_a: assert property (phy_sw_q && !chip_reset_o |-> device_ready_o)
        else $error("ready lost in PHY reset");
    phy_time_a: assert property ($fell(phy_reset_o) && phy_sw_q |->
        phy_cnt_q >= PHY_COUNT - 1 && phy_cnt_q <= PHY_COUNT + 2)
        else $error("PHY reset length wrong");
endmodule : reset_source_sequencer_assertions

bind reset_source_sequencer reset_source_sequencer_assertions #(
    .POR_COUNT(POR_COUNT),
    .PHY_COUNT(PHY_COUNT)
) reset_source_sequencer_assertions_i (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .hw_reset_pin_n_i  (hw_reset_pin_n_i),
    .hw_reset_pull_en_o(hw_reset_pull_en_o),
    .eeprom_probe_o    (eeprom_probe_o),
    .chip_reset_o      (chip_reset_o),
    .phy_reset_o       (phy_reset_o),
    .device_ready_o    (device_ready_o)
);

/* verif/eeprom_model.sv */
`timescale 1ns/100ps
module eeprom_model #(
    parameter int unsigned DELAY = 40
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Probe handshake
    input  wire logic probe_i,
    output logic      done_o
);
    int unsigned cnt_q;
    logic        busy_q;

    // A probe takes DELAY cycles, then one done cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            cnt_q  <= 0;
        end else if (probe_i) begin
            busy_q <= 1'b1;
            cnt_q  <= 0;
        end else if (busy_q) begin
            busy_q <= cnt_q < DELAY;
            cnt_q  <= cnt_q + 1;
        end
    end

    assign done_o = busy_q && cnt_q == DELAY;
endmodule : eeprom_model

/* verif/reset_source_sequencer_tb.sv */
`timescale 1ns/100ps
module reset_source_sequencer_tb;
    import rst_seq_pkg::*;

    localparam int POR_C  = 50;
    localparam int PHY_C  = 30;
    localparam int WAKE_C = 20;
    localparam int LIMIT  = 20000;

    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic [3:0]  sel      = 4'hf;
    logic [31:0] wdat     = 32'h0000_0000;
    logic        pin_n    = 1'b1;
    logic        ack;
    logic [31:0] rdat;
    logic        pull_en;
    logic        probe;
    logic        probe_done;
    logic        chip_rst;
    logic        phy_rst;
    logic        ready;
    logic        sleep;
    int          failures = 0;
    int          checks   = 0;
    int          cycles   = 0;
    logic [31:0] rd;
    int          n;

    reset_source_sequencer #(.POR_COUNT(POR_C), .PHY_COUNT(PHY_C), .WAKE_COUNT(WAKE_C)) reset_source_sequencer_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .hw_reset_pin_n_i(pin_n), .hw_reset_pull_en_o(pull_en), .eeprom_probe_o(probe),
        .eeprom_probe_done_i(probe_done), .chip_reset_o(chip_rst), .phy_reset_o(phy_rst),
        .device_ready_o(ready), .sleep_o(sleep));

    eeprom_model #(.DELAY(40)) eeprom_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .probe_i(probe), .done_o(probe_done));

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles >= LIMIT) begin
            failures = failures + 1;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        check(32'(k), 32'h0000_0002);
    endtask : bus

    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int t0;
        t0 = cycles;
        do bus(1'b0, a, '0);
        while (rd[b] !== v && cycles - t0 < 3000);
        n = cycles - t0;
    endtask : poll

    task automatic t_por;
        bus(1'b0, OFS_PM_CTRL, '0);
        check({31'h0, rd[0]}, 32'h0);
        poll(OFS_PM_CTRL, 0, 1'b1);
        check({31'h0, n >= POR_C && n <= POR_C + 8}, 32'h1);
        bus(1'b0, OFS_EEPROM_COMMAND_REG, '0);
        check(rd, 32'h8000_0000);
        poll(OFS_EEPROM_COMMAND_REG, 31, 1'b0);
        bus(1'b1, 8'h20, 32'hffff_ffff);
        bus(1'b0, 8'h20, '0);
        check(rd, 32'h0000_0000);
        $display("power-up test done");
    endtask : t_por

    task automatic t_soft;
        bus(1'b1, OFS_STA_LO, 32'h1234_5678);
        bus(1'b1, OFS_EEPROM_COMMAND_REG, 32'h0000_0042);
        bus(1'b1, OFS_HW_CONFIG_REG, 32'h00a5_0000);
        bus(1'b1, OFS_HW_CONFIG_REG, 32'h00a5_0001);
        bus(1'b0, OFS_HW_CONFIG_REG, '0);
        check({30'h0, rd[0], ready}, 32'h2);
        poll(OFS_HW_CONFIG_REG, 0, 1'b0);
        check({31'h0, n >= SOFT_CYCLES - 8 && n <= SOFT_CYCLES + 8}, 32'h1);
        check(rd, 32'h00a0_0000);
        bus(1'b0, OFS_STA_LO, '0);
        check(rd, 32'h1234_5678);
        bus(1'b0, OFS_EEPROM_COMMAND_REG, '0);
        check(rd, 32'h8000_0000);
        poll(OFS_EEPROM_COMMAND_REG, 31, 1'b0);
        $display("soft reset test done");
    endtask : t_soft

    task automatic t_phy;
        bus(1'b1, OFS_PM_CTRL, 32'h0000_0400);
        bus(1'b0, OFS_PM_CTRL, '0);
        check(rd, 32'h0000_0401);
        check({30'h0, chip_rst, phy_rst}, 32'h1);
        poll(OFS_PM_CTRL, 10, 1'b0);
        check({31'h0, n >= PHY_C - 8 && n <= PHY_C + 8}, 32'h1);
        check(rd, 32'h0000_0001);
        bus(1'b1, OFS_PHY_BC, 32'h0000_8000);
        bus(1'b0, OFS_PHY_BC, '0);
        check({rd[15], phy_rst, ready}, 3'b111);
        poll(OFS_PHY_BC, 15, 1'b0);
        check(rd, 32'h0000_0000);
        bus(1'b0, OFS_STA_LO, '0);
        check(rd, 32'h1234_5678);
        $display("PHY reset test done");
    endtask : t_phy

    task automatic t_sleep;
        bus(1'b1, OFS_PM_CTRL, 32'h0000_1000);
        bus(1'b1, OFS_WAKE, 32'h0000_0000);
        bus(1'b0, OFS_PM_CTRL, '0);
        check({30'h0, rd[0], sleep}, 32'h1);
        check({31'h0, sleep}, 32'h1);
        bus(1'b1, OFS_WAKE, 32'h0000_0000);
        poll(OFS_PM_CTRL, 0, 1'b1);
        check({31'h0, n <= WAKE_C + 8}, 32'h1);
        check({rd[31:1], sleep}, 32'h0000_0000);
        $display("wake test done");
    endtask : t_sleep

    task automatic t_pin;
        @(posedge clk_i);
        pin_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({29'h0, chip_rst, phy_rst, ready}, 32'h6);
        pin_n <= 1'b1;
        poll(OFS_PM_CTRL, 0, 1'b1);
        check({31'h0, n <= 12}, 32'h1);
        bus(1'b0, OFS_STA_LO, '0);
        check(rd, 32'h0000_0000);
        bus(1'b0, OFS_EEPROM_COMMAND_REG, '0);
        check(rd, 32'h8000_0000);
        $display("pin reset test done");
    endtask : t_pin

    task automatic test_done;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check({31'h0, pull_en}, 32'h1);
        t_por();
        t_soft();
        t_phy();
        t_sleep();
        t_pin();
        test_done();
    end
endmodule : reset_source_sequencer_tb
